// ### hdl/printer_port_pkg.sv
// Constants and types of the printer port register block
`default_nettype none
package printer_port_pkg;
  // Selectable base addresses
  localparam logic [15:0] BASE_A = 16'h0278;
  localparam logic [15:0] BASE_B = 16'h0378;
  localparam logic [15:0] BASE_C = 16'h03BC;
  // Offsets from the base
  localparam logic [11:0] OFS_DATA = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h001;
  localparam logic [11:0] OFS_CTRL = 12'h002;
  localparam logic [11:0] OFS_EPP_ADDR = 12'h003;
  localparam logic [11:0] OFS_EPP_DATA = 12'h004;
  localparam logic [11:0] OFS_FIFO = 12'h400;
  localparam logic [11:0] OFS_CFG_B = 12'h401;
  localparam logic [11:0] OFS_ECR = 12'h402;
  // Mode numbers in extended_mode_control bits 5-3
  localparam logic [2:0] MODE_STD = 3'h0;
  localparam logic [2:0] MODE_BIDI = 3'h1;
  localparam logic [2:0] MODE_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_EPP = 3'h4;
  localparam logic [2:0] MODE_TEST = 3'h5;
  localparam logic [2:0] MODE_CFG = 3'h6;
  // printer_line_control bit positions
  localparam int CTRL_STROBE = 0;
  localparam int CTRL_AUTO_LINE_FEED_N = 1;
  localparam int CTRL_INIT = 2;
  localparam int CTRL_SELIN = 3;
  localparam int CTRL_PORT_IRQ_ENABLE = 4;
  localparam int CTRL_DIR = 5;
  // Values after reset
  localparam logic [5:0] CTRL_RESET = 6'h04;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [5:0] ECR_RESET = 6'h05;
  localparam logic [7:0] CFG_B_RESET = 8'h00;
  localparam logic [7:0] CFG_A_VALUE = 8'h10;
  // FIFO shape
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  // Handshake timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETUP_NS = 500;
  localparam int PULSE_NS = 500;
  localparam int HOLD_NS = 500;
  localparam int ADDR_PULSE_NS = 250;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_PULSE_CYC = (ADDR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SETUP_CNT = 8'(SETUP_CYC);
  localparam logic [7:0] PULSE_CNT = 8'(PULSE_CYC);
  localparam logic [7:0] HOLD_CNT = 8'(HOLD_CYC);
  localparam logic [7:0] ADDR_PULSE_CNT = 8'(ADDR_PULSE_CYC);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_PULSE = 4'b0100,
    ST_HOLD = 4'b1000
  } xfer_state_t;

  typedef enum logic [1:0] {
    KIND_DATA = 2'h0,
    KIND_ADDR = 2'h1,
    KIND_CMD = 2'h2
  } xfer_kind_t;

  typedef struct packed {
    logic [7:0] data;
    logic fault_n;
    logic online;
    logic paper_out;
    logic ack_n;
    logic busy;
  } pins_t;

  typedef struct packed {
    logic tag;
    logic [7:0] value;
  } fifo_entry_t;
endpackage
`default_nettype wire

// ### hdl/printer_port.sv
// Printer port register block with FIFO and peripheral handshake engine
`default_nettype none
module printer_port (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] base_sel_i,
  input wire logic extended_modes_en_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic [7:0] pdata_i,
  output logic [7:0] pdata_o,
  output logic pdata_oe_n_o,
  input wire logic fault_n_i,
  input wire logic printer_online_i,
  input wire logic paper_out_i,
  input wire logic ack_n_i,
  input wire logic busy_i,
  output logic strobe_n_o,
  output logic auto_line_feed_n_o,
  output logic init_n_o,
  output logic printer_select_in_n_o,
  output logic addr_strobe_n_o,
  output logic port_irq_o
);
  localparam int ASTB_AT = printer_port_pkg::SETUP_CYC + 1;

  localparam int FIFO_AW_W = printer_port_pkg::FIFO_AW;
  printer_port_pkg::pins_t raw_pins, meta_pins, pins;
  printer_port_pkg::xfer_state_t state;
  printer_port_pkg::xfer_kind_t kind;
  printer_port_pkg::fifo_entry_t mem [printer_port_pkg::FIFO_DEPTH];
  printer_port_pkg::fifo_entry_t head;
  logic [15:0] base, diff;
  logic [11:0] ofs;
  logic [5:0] ctrl, extended_mode_control;
  logic [2:0] mode;
  logic [7:0] out_data, cfg_b, status_byte, next_rdata, cnt;
  logic [FIFO_AW_W:0] wr_ptr, rd_ptr;
  logic [6:0] run_len, repeat_left;
  logic hit, full, empty, push, pop, epp_read, ack_prev, irq_pending;
  logic wr_data, wr_ctrl, wr_eppa, wr_eppd, rd_eppd, wr_fifo, wr_afifo;
  logic rd_fifo, rd_status, wr_cfgb, wr_ecr, epp_go, eng_pop, drain_mode, drive_lines;

  // Address decode against the selected base
  always_comb begin
    if (base_sel_i == 2'h0) begin
      base = printer_port_pkg::BASE_A;
    end else if (base_sel_i == 2'h1) begin
      base = printer_port_pkg::BASE_B;
    end else begin
      base = printer_port_pkg::BASE_C;
    end
    diff = io_addr_i - base;
    ofs = diff[11:0];
    hit = (diff[15:3] == 13'h0000) ||
          ((diff[15:2] == 14'h0100) && (diff[1:0] != 2'h3));
  end
  assign mode = extended_mode_control[5:3];
  assign wr_data = io_wr_i && hit && ofs == printer_port_pkg::OFS_DATA &&
    (mode == printer_port_pkg::MODE_STD || mode == printer_port_pkg::MODE_BIDI ||
     mode == printer_port_pkg::MODE_EPP);
  assign wr_afifo = io_wr_i && hit && ofs == printer_port_pkg::OFS_DATA &&
    mode == printer_port_pkg::MODE_ECP;
  assign rd_status = io_rd_i && hit && ofs == printer_port_pkg::OFS_STATUS;
  assign wr_ctrl = io_wr_i && hit && ofs == printer_port_pkg::OFS_CTRL;
  assign wr_eppa = io_wr_i && hit && ofs == printer_port_pkg::OFS_EPP_ADDR &&
    mode == printer_port_pkg::MODE_EPP;
  assign wr_eppd = io_wr_i && hit && ofs[11:2] == printer_port_pkg::OFS_EPP_DATA[11:2] &&
    mode == printer_port_pkg::MODE_EPP;
  assign rd_eppd = io_rd_i && hit && ofs[11:2] == printer_port_pkg::OFS_EPP_DATA[11:2] &&
    mode == printer_port_pkg::MODE_EPP;
  assign wr_fifo = io_wr_i && hit && ofs == printer_port_pkg::OFS_FIFO &&
    (mode == printer_port_pkg::MODE_FIFO || mode == printer_port_pkg::MODE_ECP ||
     mode == printer_port_pkg::MODE_TEST);
  assign rd_fifo = io_rd_i && hit && ofs == printer_port_pkg::OFS_FIFO &&
    mode == printer_port_pkg::MODE_TEST;
  assign wr_cfgb = io_wr_i && hit && ofs == printer_port_pkg::OFS_CFG_B &&
    mode == printer_port_pkg::MODE_CFG;
  assign wr_ecr = io_wr_i && hit && ofs == printer_port_pkg::OFS_ECR;
  // Two-stage synchronisers on every connector input
  assign raw_pins = '{data: pdata_i, fault_n: fault_n_i, online: printer_online_i,
                      paper_out: paper_out_i, ack_n: ack_n_i, busy: busy_i};
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta_pins <= '1; // Idle-high levels, so no false ack edge after reset
      pins <= '1;
    end else begin
      meta_pins <= raw_pins;
      pins <= meta_pins;
    end
  end
  // Host-written registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl <= printer_port_pkg::CTRL_RESET;
      extended_mode_control <= printer_port_pkg::ECR_RESET;
      cfg_b <= printer_port_pkg::CFG_B_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= io_wdata_i[5:0];
      end
      if (wr_ecr) begin
        extended_mode_control <= io_wdata_i[7:2];
      end
      if (wr_cfgb) begin
        cfg_b <= io_wdata_i;
      end
    end
  end
  // Tagged FIFO shared by print, packet and test modes
  assign full = (wr_ptr[FIFO_AW_W] != rd_ptr[FIFO_AW_W]) &&
                (wr_ptr[FIFO_AW_W-1:0] == rd_ptr[FIFO_AW_W-1:0]);
  assign empty = wr_ptr == rd_ptr;
  assign head = mem[rd_ptr[FIFO_AW_W-1:0]];
  assign push = (wr_fifo || wr_afifo) && !full;
  assign pop = (rd_fifo || eng_pop) && !empty;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || mode == printer_port_pkg::MODE_STD) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr[FIFO_AW_W-1:0]] <= '{tag: wr_afifo, value: io_wdata_i};
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
  // Engine drains in print mode, in packet mode only forward, never in test mode
  assign drain_mode = mode == printer_port_pkg::MODE_FIFO ||
    (mode == printer_port_pkg::MODE_ECP && !ctrl[printer_port_pkg::CTRL_DIR]);
  assign epp_go = (wr_eppa || wr_eppd || rd_eppd) && state == printer_port_pkg::ST_IDLE;
  assign eng_pop = state == printer_port_pkg::ST_IDLE && !empty && !epp_go &&
    drain_mode && pins.busy;
  // Handshake engine
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state <= printer_port_pkg::ST_IDLE;
      kind <= printer_port_pkg::KIND_DATA;
      cnt <= '0;
      run_len <= '0;
      repeat_left <= '0;
      epp_read <= 1'b0;
    end else begin
      case (state)
        printer_port_pkg::ST_IDLE: begin
          if (epp_go) begin
            kind <= wr_eppa ? printer_port_pkg::KIND_ADDR : printer_port_pkg::KIND_DATA;
            epp_read <= rd_eppd;
            repeat_left <= '0;
            cnt <= printer_port_pkg::SETUP_CNT;
            state <= printer_port_pkg::ST_SETUP;
          end else if (eng_pop) begin
            if (head.tag && !head.value[7]) begin
              run_len <= head.value[6:0];
            end else begin
              kind <= head.tag ? printer_port_pkg::KIND_CMD : printer_port_pkg::KIND_DATA;
              repeat_left <= head.tag ? 7'h00 : run_len;
              run_len <= '0;
              epp_read <= 1'b0;
              cnt <= printer_port_pkg::SETUP_CNT;
              state <= printer_port_pkg::ST_SETUP;
            end
          end
        end
        printer_port_pkg::ST_SETUP: begin
          cnt <= cnt - 1'b1;
          if (cnt == 8'h01) begin
            cnt <= (kind == printer_port_pkg::KIND_ADDR) ? printer_port_pkg::ADDR_PULSE_CNT :
                   printer_port_pkg::PULSE_CNT;
            state <= printer_port_pkg::ST_PULSE;
          end
        end
        printer_port_pkg::ST_PULSE: begin
          cnt <= cnt - 1'b1;
          if (cnt == 8'h01) begin
            cnt <= printer_port_pkg::HOLD_CNT;
            state <= printer_port_pkg::ST_HOLD;
          end
        end
        printer_port_pkg::ST_HOLD: begin
          cnt <= cnt - 1'b1;
          if (cnt == 8'h01) begin
            if (repeat_left != 7'h00) begin
              repeat_left <= repeat_left - 1'b1;
              cnt <= printer_port_pkg::SETUP_CNT;
              state <= printer_port_pkg::ST_SETUP;
            end else begin
              epp_read <= 1'b0;
              state <= printer_port_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state <= printer_port_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // Output data latch: host writes and engine loads
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      out_data <= printer_port_pkg::DATA_RESET;
    end else if (wr_data || (epp_go && !rd_eppd)) begin
      out_data <= io_wdata_i;
    end else if (eng_pop && !(head.tag && !head.value[7])) begin
      out_data <= head.value;
    end
  end
  // Acknowledge interrupt; disabling discards, a status read clears, an edge wins the read
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ack_prev <= 1'b1;
      irq_pending <= 1'b0;
    end else begin
      ack_prev <= pins.ack_n;
      if (!ctrl[printer_port_pkg::CTRL_PORT_IRQ_ENABLE]) begin
        irq_pending <= 1'b0;
      end else if (pins.ack_n && !ack_prev) begin
        irq_pending <= 1'b1;
      end else if (rd_status) begin
        irq_pending <= 1'b0;
      end
    end
  end
  // Direction: standard mode always drives, reverse only with extended modes
  assign drive_lines = !(extended_modes_en_i && ctrl[printer_port_pkg::CTRL_DIR] &&
    mode != printer_port_pkg::MODE_STD) && !epp_read;
  assign pdata_oe_n_o = !drive_lines;
  assign pdata_o = out_data;
  assign strobe_n_o = !(ctrl[printer_port_pkg::CTRL_STROBE] ||
    (state == printer_port_pkg::ST_PULSE && kind != printer_port_pkg::KIND_ADDR));
  assign addr_strobe_n_o = !(state == printer_port_pkg::ST_PULSE &&
    kind == printer_port_pkg::KIND_ADDR);
  assign auto_line_feed_n_o = !(ctrl[printer_port_pkg::CTRL_AUTO_LINE_FEED_N] ||
    (state != printer_port_pkg::ST_IDLE && kind == printer_port_pkg::KIND_CMD));
  assign init_n_o = ctrl[printer_port_pkg::CTRL_INIT];
  assign printer_select_in_n_o = !ctrl[printer_port_pkg::CTRL_SELIN];
  assign port_irq_o = irq_pending;
  assign status_byte = {pins.busy, pins.ack_n, pins.paper_out, pins.online,
                        !pins.fault_n, 3'h0};
  // Read mux; reads land one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (!hit) begin
      next_rdata = 8'h00;
    end else if (ofs == printer_port_pkg::OFS_DATA) begin
      next_rdata = pins.data;
    end else if (ofs == printer_port_pkg::OFS_STATUS) begin
      next_rdata = status_byte;
    end else if (ofs == printer_port_pkg::OFS_CTRL) begin
      next_rdata = {2'h0, ctrl};
    end else if (ofs[11:2] == printer_port_pkg::OFS_EPP_DATA[11:2] ||
                 ofs == printer_port_pkg::OFS_EPP_ADDR) begin
      next_rdata = (mode == printer_port_pkg::MODE_EPP) ? pins.data : 8'h00;
    end else if (ofs == printer_port_pkg::OFS_FIFO) begin
      if (mode == printer_port_pkg::MODE_CFG) begin
        next_rdata = printer_port_pkg::CFG_A_VALUE;
      end else if (mode == printer_port_pkg::MODE_TEST) begin
        next_rdata = head.value;
      end
    end else if (ofs == printer_port_pkg::OFS_CFG_B) begin
      if (mode == printer_port_pkg::MODE_CFG) begin
        next_rdata = {1'b0, irq_pending, 6'h00};
      end
    end else if (ofs == printer_port_pkg::OFS_ECR) begin
      next_rdata = {extended_mode_control, full, empty};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_rd_i) begin
      io_rdata_o <= next_rdata;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_unmapped_zero;
    io_rd_i && !hit |=> io_rdata_o == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_status_low;
    rd_status |=> io_rdata_o[2:0] == 3'h0 && io_rdata_o[3] == !$past(pins.fault_n);
  endproperty
  a_status_low: assert property (p_status_low) else $error("status fault bits wrong");
  property p_status_high;
    rd_status |=> io_rdata_o[7] == $past(pins.busy) && io_rdata_o[5] == $past(pins.paper_out);
  endproperty
  a_status_high: assert property (p_status_high) else $error("status busy or paper wrong");
  property p_strobe_ctrl;
    wr_ctrl && io_wdata_i[0] |=> !strobe_n_o;
  endproperty
  a_strobe_ctrl: assert property (p_strobe_ctrl) else $error("strobe not asserted");
  property p_init_follow;
    wr_ctrl |=> init_n_o == $past(io_wdata_i[2]);
  endproperty
  a_init_follow: assert property (p_init_follow) else $error("init line mismatch");
  property p_irq_discard;
    wr_ctrl && !io_wdata_i[4] |-> ##2 !port_irq_o;
  endproperty
  a_irq_discard: assert property (p_irq_discard) else $error("interrupt not discarded");
  property p_std_drive;
    mode == printer_port_pkg::MODE_STD && state == printer_port_pkg::ST_IDLE |-> !pdata_oe_n_o;
  endproperty
  a_std_drive: assert property (p_std_drive) else $error("standard mode not driving");
  property p_addr_strobe;
    wr_eppa && state == printer_port_pkg::ST_IDLE |-> addr_strobe_n_o [*2] ##(ASTB_AT - 1)
      !addr_strobe_n_o;
  endproperty
  a_addr_strobe: assert property (p_addr_strobe) else $error("address strobe timing");
  property p_fifo_send;
    eng_pop && !head.tag |=> state == printer_port_pkg::ST_SETUP && pdata_o == $past(head.value);
  endproperty
  a_fifo_send: assert property (p_fifo_send) else $error("FIFO byte not sent");
  property p_run_length;
    eng_pop && head.tag && !head.value[7] |=>
      state == printer_port_pkg::ST_IDLE && run_len == $past(head.value[6:0]);
  endproperty
  a_run_length: assert property (p_run_length) else $error("run length not captured");
  property p_test_quiet;
    mode == printer_port_pkg::MODE_TEST && state == printer_port_pkg::ST_IDLE |=>
      state == printer_port_pkg::ST_IDLE;
  endproperty
  a_test_quiet: assert property (p_test_quiet) else $error("test mode sent data");
  property p_mode_write;
    wr_ecr |=> mode == $past(io_wdata_i[7:5]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode not written");

  c_irq: cover property (ctrl[printer_port_pkg::CTRL_PORT_IRQ_ENABLE] ##1 port_irq_o);
  c_epp_addr: cover property (!addr_strobe_n_o);
  c_fifo_send: cover property (eng_pop && !head.tag);
  c_repeat: cover property (state == printer_port_pkg::ST_HOLD && repeat_left != 7'h00);
endmodule
`default_nettype wire

// ### verif/printer_model.sv
// Peripheral model on the connector side of the printer port
`default_nettype none
module printer_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] pdata_i,
  input wire logic oe_n_i,
  input wire logic strobe_n_i,
  input wire logic auto_line_feed_n_i,
  input wire logic [7:0] drive_i,
  input wire logic ack_low_i,
  output logic [7:0] line_o,
  output logic ack_n_o,
  output int strobes_o,
  output logic [7:0] last_o,
  output logic last_af_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev;
  logic [3:0] pulse;
  // Released lines show the model's own byte, never a stale copy
  assign line_o = oe_n_i ? drive_i : pdata_i;
  assign ack_n_o = !(ack_low_i || pulse != 4'h0);
  initial begin
    prev = 1'b1;
    pulse = 4'h0;
    strobes_o = 0;
    last_o = 8'h00;
    last_af_n_o = 1'b1;
  end
  always @(posedge ref_clk_i) begin
    prev <= strobe_n_i;
    if (prev && !strobe_n_i) begin
      strobes_o <= strobes_o + 1;
      last_o <= line_o;
      last_af_n_o <= auto_line_feed_n_i;
    end
    // Acknowledge after each strobe ends
    if (!prev && strobe_n_i) begin
      pulse <= 4'h8;
    end else if (pulse != 4'h0) begin
      pulse <= pulse - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Register level testbench of the printer port
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] base_sel = 2'h1;
  logic ext_en = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic fault_n = 1'b1, online = 1'b1, paper = 1'b0, busy = 1'b1, ack_low = 1'b0;
  logic [7:0] rdata, pdata, line, last, rv, exp_s;
  logic oe_n, stb_n, af_n, init_n, sel_n, as_n, irq, last_af, ack_n;
  logic [15:0] base = printer_port_pkg::BASE_B;
  logic [4:0] pats [4] = '{5'h15, 5'h0a, 5'h1f, 5'h00};
  int fails = 0, checked = 0, cycles = 0, s0, strobes, i;
  always #5 ref_clk_i = ~ref_clk_i;
  printer_port dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .base_sel_i(base_sel),
    .extended_modes_en_i(ext_en), .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd),
    .io_wdata_i(io_wdata), .io_rdata_o(rdata), .pdata_i(line), .pdata_o(pdata),
    .pdata_oe_n_o(oe_n), .fault_n_i(fault_n), .printer_online_i(online), .paper_out_i(paper),
    .ack_n_i(ack_n), .busy_i(busy), .strobe_n_o(stb_n), .auto_line_feed_n_o(af_n),
    .init_n_o(init_n), .printer_select_in_n_o(sel_n), .addr_strobe_n_o(as_n), .port_irq_o(irq));
  printer_model peer_u (.ref_clk_i(ref_clk_i), .pdata_i(pdata), .oe_n_i(oe_n),
    .strobe_n_i(stb_n), .auto_line_feed_n_i(af_n), .drive_i(8'h5a), .ack_low_i(ack_low),
    .line_o(line), .ack_n_o(ack_n), .strobes_o(strobes), .last_o(last), .last_af_n_o(last_af));
  task automatic summarize;
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles++;
    // Whole run needs well under this
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [11:0] ofs, input logic [7:0] d);
    @(posedge ref_clk_i);
    io_addr <= base + 16'(ofs);
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge ref_clk_i);
    io_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] ofs, input logic [7:0] exp);
    @(posedge ref_clk_i);
    io_addr <= base + 16'(ofs);
    io_rd <= 1'b1;
    @(posedge ref_clk_i);
    io_rd <= 1'b0;
    // Read data stands until the next read, so take it one edge later
    @(posedge ref_clk_i);
    rv = rdata;
    chk(rv, exp);
  endtask
  initial begin
    idle(10);
    rst_n_i <= 1'b1;
    idle(2);
    rchk(printer_port_pkg::OFS_CTRL, 8'h04);
    rchk(printer_port_pkg::OFS_ECR, 8'h15);
    for (i = 0; i < 4; i++) begin
      {busy, ack_low, paper, online, fault_n} <= pats[i];
      idle(4);
      exp_s = {pats[i][4], ~pats[i][3], pats[i][2], pats[i][1], ~pats[i][0], 3'h0};
      rchk(printer_port_pkg::OFS_STATUS, exp_s);
    end
    {busy, ack_low, paper, online, fault_n} <= 5'h13;
    wr(printer_port_pkg::OFS_DATA, 8'hc3);
    idle(50);
    chk(pdata, 8'hc3);
    for (i = 0; i < 4; i++) begin
      wr(printer_port_pkg::OFS_CTRL, 8'h04 ^ (8'h01 << i));
      idle(1);
      chk({4'h0, sel_n, init_n, af_n, stb_n}, 8'h0f ^ (8'h01 << i));
      if (i == 0) idle(5000);
    end
    idle(20);
    chk({7'h0, irq}, 8'h00);
    wr(printer_port_pkg::OFS_CTRL, 8'he4);
    rchk(printer_port_pkg::OFS_CTRL, 8'h24);
    ext_en <= 1'b1;
    idle(1);
    chk({7'h0, oe_n}, 8'h00);
    wr(printer_port_pkg::OFS_ECR, 8'h24);
    idle(1);
    chk({7'h0, oe_n}, 8'h01);
    idle(4);
    rchk(printer_port_pkg::OFS_DATA, 8'h5a);
    ext_en <= 1'b0;
    idle(1);
    chk({7'h0, oe_n}, 8'h00);
    wr(printer_port_pkg::OFS_ECR, 8'h04);
    wr(printer_port_pkg::OFS_CTRL, 8'h14);
    wr(printer_port_pkg::OFS_CTRL, 8'h15);
    idle(5000);
    wr(printer_port_pkg::OFS_CTRL, 8'h14);
    idle(20);
    chk({7'h0, irq}, 8'h01);
    wr(printer_port_pkg::OFS_CTRL, 8'h04);
    idle(2);
    chk({7'h0, irq}, 8'h00);
    rchk(12'h010, 8'h00);
    rchk(printer_port_pkg::OFS_EPP_ADDR, 8'h00);
    base_sel <= 2'h2;
    base <= printer_port_pkg::BASE_C;
    rchk(printer_port_pkg::OFS_STATUS, 8'hd0);
    base <= printer_port_pkg::BASE_A;
    rchk(printer_port_pkg::OFS_STATUS, 8'h00);
    base_sel <= 2'h1;
    base <= printer_port_pkg::BASE_B;
    wr(printer_port_pkg::OFS_ECR, 8'h44);
    s0 = strobes;
    wr(printer_port_pkg::OFS_FIFO, 8'h96);
    idle(200);
    chk(8'(strobes - s0), 8'h01);
    chk(last, 8'h96);
    wr(printer_port_pkg::OFS_ECR, 8'h64);
    s0 = strobes;
    wr(printer_port_pkg::OFS_DATA, 8'h02);
    wr(printer_port_pkg::OFS_FIFO, 8'h3c);
    idle(600);
    chk(8'(strobes - s0), 8'h03);
    chk(last, 8'h3c);
    s0 = strobes;
    wr(printer_port_pkg::OFS_DATA, 8'h85);
    idle(200);
    chk(8'(strobes - s0), 8'h01);
    chk({7'h0, last_af}, 8'h00);
    wr(printer_port_pkg::OFS_ECR, 8'h84);
    wr(printer_port_pkg::OFS_EPP_ADDR, 8'h4b);
    for (i = 0; i < 300 && as_n !== 1'b0; i++) idle(1);
    chk({7'h0, as_n}, 8'h00);
    chk(pdata, 8'h4b);
    idle(150);
    s0 = strobes;
    wr(12'h007, 8'he1);
    idle(200);
    chk(8'(strobes - s0), 8'h01);
    chk(last, 8'he1);
    ext_en <= 1'b1;
    wr(printer_port_pkg::OFS_CTRL, 8'h24);
    idle(4);
    rchk(12'h004, 8'h5a);
    idle(200);
    wr(printer_port_pkg::OFS_ECR, 8'ha4);
    s0 = strobes;
    wr(printer_port_pkg::OFS_FIFO, 8'h11);
    wr(printer_port_pkg::OFS_FIFO, 8'h22);
    rchk(printer_port_pkg::OFS_FIFO, 8'h11);
    rchk(printer_port_pkg::OFS_FIFO, 8'h22);
    idle(200);
    chk(8'(strobes - s0), 8'h00);
    rchk(printer_port_pkg::OFS_ECR, 8'ha5);
    wr(printer_port_pkg::OFS_ECR, 8'hc4);
    rchk(printer_port_pkg::OFS_FIFO, 8'h10);
    summarize();
  end
endmodule
`default_nettype wire
